// ---- core/ssc_pkg.sv ----
// package of constants and types for the shifter status and counter block
package ssc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] SSC_STATUS_INDEX = 12'h0b9;
	localparam logic [11:0] SSC_STATUS_ADDR  = {SSC_STATUS_INDEX[9:0], 2'h0};
	localparam logic [11:0] SSC_CONTROL_ADDR = 12'h100;
	localparam logic [11:0] SSC_SHIFT_ADDR   = 12'h104;
	localparam logic [11:0] SSC_MISC_ADDR    = 12'h108;

	// ****************************************
	// status fields
	// ****************************************
	localparam int SSC_START_BIT = 7;
	localparam int SSC_WRAP_BIT  = 6;
	localparam int SSC_STOP_BIT  = 5;
	localparam int SSC_COLL_BIT  = 4;
	localparam logic [7:0] SSC_STATUS_RESET = 8'h00;

	// ****************************************
	// control fields
	// ****************************************
	localparam int SSC_SIE_BIT  = 7;
	localparam int SSC_OIE_BIT  = 6;
	localparam int SSC_WM_LSB   = 4;
	localparam int SSC_CS_LSB   = 2;
	localparam int SSC_SCLK_BIT = 1;
	localparam int SSC_TC_BIT   = 0;
	localparam logic [7:0] SSC_CONTROL_RESET = 8'h00;

	// misc register: bit0 global irq enable, bits2:1 sleep mode
	localparam int SSC_GIE_BIT   = 0;
	localparam int SSC_SLEEP_LSB = 1;

	localparam logic [1:0] SSC_WM_NONE  = 2'h0;
	localparam logic [1:0] SSC_WM_THREE = 2'h1;
	localparam logic [1:0] SSC_WM_TWO   = 2'h2;
	localparam logic [1:0] SSC_SLEEP_IDLE = 2'h0;

	typedef struct packed {
		logic [1:0] wire_mode_sel;
		logic [1:0] clock_source_sel;
		logic       soft_clock_select;
		logic       start_irq_enable;
		logic       wrap_irq_enable;
	} ssc_ctrl_t;

	typedef struct packed {
		logic start_irq;
		logic wrap_irq;
		logic wake;
		logic clk_hold;
	} ssc_evt_t;

endpackage

// ---- core/ssc_status.sv ----
// shifter status register, edge counter and apb slave
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module ssc_status (
	input  wire logic             pclk,           // system clock
	input  wire logic             presetn,        // async reset, low
	input  wire logic             psel,           // apb select
	input  wire logic             penable,        // apb enable
	input  wire logic             pwrite,         // apb direction
	input  wire logic [11:0]      paddr,          // apb byte address
	input  wire logic [31:0]      pwdata,         // apb write data
	output logic      [31:0]      prdata,         // apb read data
	output logic                  pready,         // apb ready
	output logic                  pslverr,        // apb error
	input  wire logic             shift_clock_pin, // external clock pin
	input  wire logic             data_pin,       // data pin level
	input  wire logic             timer_match,    // timer 0 compare pulse
	input  wire logic             start_det,      // start condition pulse
	input  wire logic             stop_det,       // stop condition pulse
	output ssc_pkg::ssc_evt_t     evt             // irq, wake, clock hold
);
	import ssc_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	ssc_ctrl_t  ctrl;
	logic       gie;
	logic [1:0] sleep_mode;
	logic [7:0] shift_data;
	logic       start_cond_flag;
	logic       count_wrap_flag;
	logic       stop_cond_flag;
	logic       drive_collision_bit;
	logic [3:0] edge_count_value;
	logic       start_hold;
	logic       wrap_hold;
	logic [2:0] ck_sync;
	logic [2:0] d_sync;
	logic       ck_level;
	logic       d_level;

	logic wr_en;
	logic wr_stat;
	logic wr_ctrl;
	logic strobe_tc;
	logic ext_edge;
	logic tick;
	logic next_wrap;
	logic two_wire;

	assign wr_en     = psel && penable && pwrite;
	assign wr_stat   = wr_en && (paddr == SSC_STATUS_ADDR);
	assign wr_ctrl   = wr_en && (paddr == SSC_CONTROL_ADDR);
	assign strobe_tc = wr_ctrl && pwdata[SSC_TC_BIT];
	assign two_wire  = (ctrl.wire_mode_sel == SSC_WM_TWO);

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_sync  <= 3'h0;
			d_sync   <= 3'h0;
			ck_level <= 1'b0;
			d_level  <= 1'b0;
		end else begin
			ck_sync <= {ck_sync[1:0], shift_clock_pin};
			d_sync  <= {d_sync[1:0], data_pin};
			if (ck_sync[1] == ck_sync[2])
				ck_level <= ck_sync[2];
			if (d_sync[1] == d_sync[2])
				d_level <= d_sync[2];
		end
	end

	// ****************************************
	// counter clock source
	// ****************************************
	// cs 00 none/soft, 01 timer, 1x external rising/falling by cs[0]
	always_comb begin
		ext_edge = (ck_sync[1] == ck_sync[2]) && (ck_sync[2] != ck_level) &&
		           (ck_sync[2] ^ ctrl.clock_source_sel[0]);
		case (ctrl.clock_source_sel)
			2'h0:    tick = ctrl.soft_clock_select && strobe_tc;
			2'h1:    tick = timer_match;
			default: tick = ext_edge || (ctrl.soft_clock_select && strobe_tc);
		endcase
	end

	assign next_wrap = tick && (edge_count_value == 4'hf);

	// ****************************************
	// control and misc registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl       <= '0;
			gie        <= 1'b0;
			sleep_mode <= SSC_SLEEP_IDLE;
			shift_data <= 8'h00;
		end else if (wr_en) begin
			case (paddr)
				SSC_CONTROL_ADDR: begin
					ctrl.start_irq_enable  <= pwdata[SSC_SIE_BIT];
					ctrl.wrap_irq_enable   <= pwdata[SSC_OIE_BIT];
					ctrl.wire_mode_sel     <= pwdata[SSC_WM_LSB +: 2];
					ctrl.clock_source_sel  <= pwdata[SSC_CS_LSB +: 2];
					ctrl.soft_clock_select <= pwdata[SSC_SCLK_BIT];
				end
				SSC_SHIFT_ADDR: shift_data <= pwdata[7:0];
				SSC_MISC_ADDR: begin
					gie        <= pwdata[SSC_GIE_BIT];
					sleep_mode <= pwdata[SSC_SLEEP_LSB +: 2];
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// edge counter
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			edge_count_value <= SSC_STATUS_RESET[3:0];
		else if (wr_stat)
			edge_count_value <= pwdata[3:0];
		else if (tick)
			edge_count_value <= edge_count_value + 4'h1;
	end

	// ****************************************
	// event flags, set wins over clear
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_cond_flag <= 1'b0;
			count_wrap_flag <= 1'b0;
			stop_cond_flag  <= 1'b0;
		end else begin
			if ((two_wire && start_det) || (!two_wire && tick))
				start_cond_flag <= 1'b1;
			else if (wr_stat && pwdata[SSC_START_BIT])
				start_cond_flag <= 1'b0;
			if (next_wrap)
				count_wrap_flag <= 1'b1;
			else if (wr_stat && pwdata[SSC_WRAP_BIT])
				count_wrap_flag <= 1'b0;
			if (two_wire && stop_det)
				stop_cond_flag <= 1'b1;
			else if (wr_stat && pwdata[SSC_STOP_BIT])
				stop_cond_flag <= 1'b0;
		end
	end

	// ****************************************
	// clock-line holds
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_hold <= 1'b0;
			wrap_hold  <= 1'b0;
		end else begin
			if (two_wire && start_det)
				start_hold <= 1'b1;
			else if (!two_wire || (wr_stat && pwdata[SSC_START_BIT]))
				start_hold <= 1'b0;
			if (two_wire && next_wrap)
				wrap_hold <= 1'b1;
			else if (!two_wire || (wr_stat && pwdata[SSC_WRAP_BIT]))
				wrap_hold <= 1'b0;
		end
	end

	// ****************************************
	// collision and outputs
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_collision_bit <= 1'b0;
			evt                 <= '0;
		end else begin
			drive_collision_bit <= shift_data[7] != d_level;
			evt.start_irq <= start_cond_flag && ctrl.start_irq_enable && gie;
			evt.wrap_irq  <= count_wrap_flag && ctrl.wrap_irq_enable && gie;
			evt.wake      <= (start_cond_flag && ctrl.start_irq_enable && gie) ||
			                 (count_wrap_flag && ctrl.wrap_irq_enable && gie &&
			                  sleep_mode == SSC_SLEEP_IDLE);
			evt.clk_hold  <= start_hold || wrap_hold;
		end
	end

	// ****************************************
	// apb read side
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					SSC_STATUS_ADDR:  prdata <= {24'h0, start_cond_flag, count_wrap_flag,
					                   stop_cond_flag, drive_collision_bit,
					                   edge_count_value};
					SSC_CONTROL_ADDR: prdata <= {24'h0, ctrl.start_irq_enable,
					                   ctrl.wrap_irq_enable, ctrl.wire_mode_sel,
					                   ctrl.clock_source_sel, ctrl.soft_clock_select, 1'b0};
					SSC_SHIFT_ADDR:   prdata <= {24'h0, shift_data};
					SSC_MISC_ADDR:    prdata <= {29'h0, sleep_mode, gie};
					default:          pslverr <= 1'b1;
				endcase
			end else if (psel && !penable) begin
				case (paddr)
					SSC_STATUS_ADDR, SSC_CONTROL_ADDR, SSC_SHIFT_ADDR, SSC_MISC_ADDR: ;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

// ---- tb/ssc_chk.sv ----
// port assertions for the shifter status block
`timescale 1ns/1ps
module ssc_chk (
	input wire logic        pclk,        // clock
	input wire logic        presetn,     // reset, low
	input wire logic        psel,        // select
	input wire logic        penable,     // enable
	input wire logic        pwrite,      // direction
	input wire logic [11:0] paddr,       // address
	input wire logic [31:0] pwdata,      // write data
	input wire logic [31:0] prdata,      // read data
	input wire logic        pready,      // ready
	input wire logic        pslverr,     // error
	input wire logic        timer_match, // timer pulse
	input wire logic        start_det,   // start pulse
	input wire ssc_pkg::ssc_evt_t evt    // events
);
	import ssc_pkg::*;
	logic [7:0] ctl;
	logic [7:0] msc;
	wire acc = psel && penable && pready && pwrite;
	wire tw = ctl[5:4] == SSC_WM_TWO;
	wire sie = ctl[7];
	wire oen = ctl[6] && msc[0];
	wire deep = msc[2:1] != SSC_SLEEP_IDLE;
	wire mapped = paddr inside {SSC_STATUS_ADDR, SSC_CONTROL_ADDR, SSC_SHIFT_ADDR, SSC_MISC_ADDR};
	wire w1c = acc && paddr == SSC_STATUS_ADDR && pwdata[7:6] == 2'h3;
	// shadow of control and misc writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ctl <= 8'h00;
		else if (acc && paddr == SSC_CONTROL_ADDR) ctl <= pwdata[7:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) msc <= 8'h00;
		else if (acc && paddr == SSC_MISC_ADDR) msc <= pwdata[7:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_err_unmapped: assert property (pready |-> pslverr == !mapped)
		else $error("error flag wrong");
	a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_start_irq_set: assert property (start_det && tw && sie && msc[0] |-> ##2 evt.start_irq)
		else $error("start irq missing");
	a_wrap_irq_gate: assert property (evt.wrap_irq |-> $past(oen))
		else $error("wrap irq not enabled");
	a_wake_sleep_gate: assert property (evt.wake && !$past(sie) |-> !$past(deep))
		else $error("wake from deep sleep");
	a_hold_on_start: assert property (start_det && tw |-> ##2 evt.clk_hold)
		else $error("no hold on start");
	a_hold_release: assert property (w1c && !start_det && !timer_match |-> ##2 !evt.clk_hold)
		else $error("hold not released");
	c_start: cover property (evt.start_irq);
	c_wrap: cover property (evt.wrap_irq);
	c_err: cover property (pready && pslverr);
endmodule
bind ssc_status ssc_chk ssc_chk_i (.*);

// ---- tb/ssc_peer.sv ----
// serial bus peer: link clock, data level, bus conditions
`timescale 1ns/1ps
module ssc_peer (
	input  wire logic pclk,            // system clock
	output logic      shift_clock_pin, // link clock, still between frames
	output logic      data_pin,        // data line level
	output logic      start_det,       // start pulse
	output logic      stop_det         // stop pulse
);
	initial begin
		shift_clock_pin = 1'b0;
		data_pin = 1'b0;
		start_det = 1'b0;
		stop_det = 1'b0;
	end
	task automatic clocks(input int n);
		#7;
		repeat (n) begin
			#160 shift_clock_pin = 1'b1;
			#160 shift_clock_pin = 1'b0;
		end
	endtask
	task automatic cond(input bit s);
		@(posedge pclk);
		start_det <= s;
		stop_det <= !s;
		@(posedge pclk);
		start_det <= 1'b0;
		stop_det <= 1'b0;
	endtask
	task automatic level(input logic v);
		@(posedge pclk);
		data_pin <= v;
	endtask
endmodule

// ---- tb/tb.sv ----
// bench for the shifter status block with a reference model
`timescale 1ns/1ps
module tb;
	import ssc_pkg::*;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic        timer_match = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata, q;
	logic        pready, pslverr, er, shift_clock_pin, data_pin, start_det, stop_det;
	ssc_evt_t    evt;
	int          num_errors = 0, comparisons = 0, seed = 32'h3cc88d42;
	int          ef = 0, ec = 0, eco = 0, wm = 0, pc = 0, n;
	always #20 pclk = ~pclk;
	ssc_status ssc_status_i (.*);
	ssc_peer ssc_peer_i (.*);
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
		q = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (k >= 50) num_errors++;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
		comparisons++;
		if (v !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic stat();
		apb(0, SSC_STATUS_ADDR, 32'h0);
		chk("status", ef | eco << 4 | ec, q);
	endtask
	task automatic tick();
		ec = (ec + 1) % 16;
		if (ec == 0) ef |= 8'h40;
		if (wm != 2) ef |= 8'h80;
	endtask
	task automatic ctl(input int v);
		apb(1, SSC_CONTROL_ADDR, v);
		// strobe acts through the control value already in place
		if ((v & 1) && (pc & 2) && (pc >> 2 & 3) != 1) tick();
		wm = v >> 4 & 3;
		pc = v;
	endtask
	task automatic wst(input int v);
		apb(1, SSC_STATUS_ADDR, v);
		ef &= ~(v & 8'he0);
		ec = v & 15;
	endtask
	task automatic pulse();
		@(posedge pclk);
		timer_match <= 1;
		@(posedge pclk);
		timer_match <= 0;
		tick();
	endtask
	task automatic stop_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		stat();
		apb(0, 12'h200, 32'h0);
		chk("slverr", 1, er);
		$display("test reset and map done");
		wst($random(seed) & 15);
		stat();
		ctl(8'h1a);
		repeat (17) ctl(8'h1b);
		stat();
		wst(ec);
		stat();
		wst(8'he0 | ec);
		stat();
		$display("test strobe done");
		ctl(8'h14);
		n = 1 + ($random(seed) & 7);
		repeat (n) pulse();
		stat();
		ctl(8'h08);
		repeat (n) begin
			ssc_peer_i.clocks(1);
			tick();
		end
		repeat (8) @(posedge pclk);
		stat();
		ctl(8'h0c);
		repeat (n) begin
			ssc_peer_i.clocks(1);
			tick();
		end
		repeat (8) @(posedge pclk);
		stat();
		$display("test timer and pin done");
		wst(8'he0 | ec);
		apb(1, SSC_MISC_ADDR, 32'h1);
		ctl(8'he0);
		ssc_peer_i.cond(1);
		ef |= 8'h80;
		repeat (3) @(posedge pclk);
		chk("start irq", 1, evt.start_irq);
		chk("wake", 1, evt.wake);
		chk("hold", 1, evt.clk_hold);
		stat();
		wst(8'h80 | ec);
		repeat (3) @(posedge pclk);
		chk("hold", 0, evt.clk_hold);
		ssc_peer_i.cond(0);
		ef |= 8'h20;
		repeat (3) @(posedge pclk);
		chk("start irq", 0, evt.start_irq);
		stat();
		apb(1, SSC_MISC_ADDR, 32'h5);
		ctl(8'h64);
		wst(15);
		pulse();
		repeat (3) @(posedge pclk);
		chk("wrap irq", 1, evt.wrap_irq);
		chk("wake", 0, evt.wake);
		chk("hold", 1, evt.clk_hold);
		apb(1, SSC_MISC_ADDR, 32'h1);
		repeat (2) @(posedge pclk);
		chk("wake", 1, evt.wake);
		stat();
		wst(8'he0 | ec);
		repeat (3) @(posedge pclk);
		chk("hold", 0, evt.clk_hold);
		$display("test two-wire done");
		apb(1, SSC_SHIFT_ADDR, 32'h80);
		eco = 1;
		repeat (5) @(posedge pclk);
		stat();
		ssc_peer_i.level(1);
		eco = 0;
		repeat (5) @(posedge pclk);
		stat();
		$display("test collision done");
		ssc_peer_i.level(0);
		eco = 1;
		wst(15);
		ctl(8'h02);
		ctl(8'h03);
		stat();
		@(posedge pclk);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		ef = 0;
		ec = 0;
		eco = 0;
		wm = 0;
		pc = 0;
		stat();
		$display("test soft strobe and reset done");
		stop_test();
	end
	initial begin
		#400000;
		num_errors++;
		stop_test();
	end
endmodule
